// ==== scg_pkg.sv ====
// Summary of operation
// - After suspend, internal clocking restarts the cycle after clock enable samples high.
// - Leaving power-down turns the disabled input buffers (inBufEn) back on; output drive stays off until a read.
// - During writes, mask high drops the word; mask low stores it.
// - During reads, mask low enables output drivers; mask high disables them.
// - Clock enable low during a burst suspends internal clock next cycle, state held.
// - Clock enable low with all banks idle enters power-down, buffers off but clock enable.
package scg_pkg;

  // ****************************************
  // Widths and timing
  // ****************************************
  localparam int DATA_W   = 16;
  localparam int COL_W    = 10;
  localparam int BURST_W  = 11;
  localparam int CLK_NS   = 100;
  localparam int TIS_NS   = 2;
  localparam int PDE_NS   = TIS_NS + CLK_NS;
  localparam int PDE_CYC  = (PDE_NS + CLK_NS - 1) / CLK_NS;

  // ****************************************
  // Commands and modes
  // ****************************************
  typedef enum logic [2:0] {
    SCG_CMD_NOP   = 3'h0,
    SCG_CMD_READ  = 3'h1,
    SCG_CMD_WRITE = 3'h2,
    SCG_CMD_STOP  = 3'h3,
    SCG_CMD_OTHER = 3'h4
  } scg_cmd_t;

  typedef enum logic [1:0] {
    SCG_IDLE  = 2'h0,
    SCG_READ  = 2'h1,
    SCG_WRITE = 2'h2,
    SCG_PDOWN = 2'h3
  } scg_state_t;

  localparam logic [COL_W-1:0]   COL_ZERO   = 10'h000;
  localparam logic [BURST_W-1:0] BURST_ZERO = 11'h000;
  localparam logic [BURST_W-1:0] BURST_ONE  = 11'h001;
  localparam logic [DATA_W-1:0]  DATA_ZERO  = 16'h0000;

endpackage

// ==== scg_clock_gate_mask.sv ====
`timescale 1ns/1ns
module scg_clock_gate_mask #(
  parameter int DATA_W  = scg_pkg::DATA_W,
  parameter int COL_W   = scg_pkg::COL_W,
  parameter int BURST_W = scg_pkg::BURST_W
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // Device pins, synchronised inside
  input  wire logic               clkEn,
  input  wire logic               dataMask,
  input  wire scg_pkg::scg_cmd_t  cmd,
  input  wire logic [COL_W-1:0]   colAddr,
  input  wire logic [BURST_W-1:0] burstLen,
  input  wire logic [DATA_W-1:0]  dqIn,
  // Array side
  input  wire logic [DATA_W-1:0]  arrayRdData,
  output logic                    arrayWrEn,
  output logic [COL_W-1:0]        arrayCol,
  output logic [DATA_W-1:0]       arrayWrData,
  // Data pin drive
  output logic [DATA_W-1:0]       dqOut,
  output logic                    dqOe,
  // Status
  output logic                    inBufEn,
  output logic                    clkSuspended,
  output logic                    powerDown
);

  // ****************************************
  // State
  // ****************************************
  // Pin inputs pass two flops, so the device view lags the pins by two.
  typedef struct packed {
    logic [1:0]          cke;
    logic [1:0]          dqm;
    logic [5:0]          cmdS;
    logic [2*COL_W-1:0]  colS;
    logic [2*BURST_W-1:0] lenS;
    logic [2*DATA_W-1:0] dqS;
    scg_pkg::scg_state_t state;
    logic                ckePrev;
    logic [COL_W-1:0]    col;
    logic [BURST_W-1:0]  left;
    logic                wrEn;
    logic [COL_W-1:0]    aCol;
    logic [DATA_W-1:0]   wrData;
    logic [DATA_W-1:0]   out;
    logic                oe;
  } scg_regs_t;

  scg_regs_t r_ff;
  scg_regs_t nxt_r;
  logic      cke;
  logic      dqm;
  logic      run;
  scg_pkg::scg_cmd_t c;

  always_comb begin
    nxt_r = r_ff;
    nxt_r.cke  = {r_ff.cke[0], clkEn};
    nxt_r.dqm  = {r_ff.dqm[0], dataMask};
    nxt_r.cmdS = {r_ff.cmdS[2:0], cmd};
    nxt_r.colS = {r_ff.colS[COL_W-1:0], colAddr};
    nxt_r.lenS = {r_ff.lenS[BURST_W-1:0], burstLen};
    nxt_r.dqS  = {r_ff.dqS[DATA_W-1:0], dqIn};
    cke = r_ff.cke[1];
    dqm = r_ff.dqm[1];
    c   = scg_pkg::scg_cmd_t'(r_ff.cmdS[5:3]);
    nxt_r.ckePrev = cke;
    // Clocking runs only when enable was high the previous cycle.
    run = r_ff.ckePrev;
    nxt_r.wrEn = 1'b0;
    if (run) begin
      case (r_ff.state)
        scg_pkg::SCG_IDLE: begin
          if (!cke) begin
            nxt_r.state = scg_pkg::SCG_PDOWN;
          end else if (c == scg_pkg::SCG_CMD_READ ||
                       c == scg_pkg::SCG_CMD_WRITE) begin
            nxt_r.col  = r_ff.colS[2*COL_W-1:COL_W];
            // Point the array at the first word so read data is ready.
            nxt_r.aCol = r_ff.colS[2*COL_W-1:COL_W];
            nxt_r.left = r_ff.lenS[2*BURST_W-1:BURST_W];
            nxt_r.state = (c == scg_pkg::SCG_CMD_READ) ?
                          scg_pkg::SCG_READ : scg_pkg::SCG_WRITE;
          end
        end
        scg_pkg::SCG_READ, scg_pkg::SCG_WRITE: begin
          // The next cycle is masked by ckePrev, which freezes all this.
          if (r_ff.state == scg_pkg::SCG_WRITE) begin
            nxt_r.wrEn   = !dqm;
            nxt_r.aCol   = r_ff.col;
            nxt_r.wrData = r_ff.dqS[2*DATA_W-1:DATA_W];
          end else begin
            nxt_r.out = arrayRdData;
            // Look one column ahead, since the array answers combinationally.
            nxt_r.aCol = r_ff.col + 1'b1;
          end
          nxt_r.col  = r_ff.col + 1'b1;
          nxt_r.left = r_ff.left - scg_pkg::BURST_ONE;
          if (c == scg_pkg::SCG_CMD_STOP ||
              r_ff.left <= scg_pkg::BURST_ONE) begin
            nxt_r.state = scg_pkg::SCG_IDLE;
            nxt_r.left  = scg_pkg::BURST_ZERO;
          end
        end
        scg_pkg::SCG_PDOWN: begin
          nxt_r.state = scg_pkg::SCG_IDLE;
        end
        default: begin
          nxt_r.state = scg_pkg::SCG_IDLE;
        end
      endcase
    end else if (r_ff.state == scg_pkg::SCG_PDOWN && cke) begin
      // Exit seen: buffers return as clocking restarts next cycle.
      nxt_r.state = scg_pkg::SCG_IDLE;
    end
    // Drivers mark each unmasked read word; suspended data holds.
    nxt_r.oe = run && r_ff.state == scg_pkg::SCG_READ && !dqm;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r_ff         <= '0;
      r_ff.state   <= scg_pkg::SCG_IDLE;
      r_ff.cke     <= 2'h3;
      r_ff.ckePrev <= 1'b1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign arrayWrEn    = r_ff.wrEn;
  assign arrayCol     = r_ff.aCol;
  assign arrayWrData  = r_ff.wrData;
  assign dqOut        = r_ff.out;
  assign dqOe         = r_ff.oe;
  assign clkSuspended = !r_ff.ckePrev &&
                        r_ff.state != scg_pkg::SCG_PDOWN;
  assign powerDown    = r_ff.state == scg_pkg::SCG_PDOWN;
  assign inBufEn      = r_ff.state != scg_pkg::SCG_PDOWN;

endmodule

// ==== scg_array_model.sv ====
`timescale 1ns/1ns
module scg_array_model (
  // Array port
  input  wire logic        clk,
  input  wire logic        wrEn,
  input  wire logic [9:0]  col,
  input  wire logic [15:0] wrData,
  output      logic [15:0] rdData
);
  logic [15:0] mem [1024];
  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[col] <= wrData;
    end
  end
  assign rdData = mem[col];
endmodule

// ==== scg_clock_gate_mask_monitor.sv ====
`timescale 1ns/1ns
module scg_clock_gate_mask_monitor #(
  parameter int DATA_W = 16,
  parameter int COL_W  = 10
) (
  // Clock and pins
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic              clkEn,
  input wire logic              dataMask,
  // Outputs
  input wire logic              arrayWrEn,
  input wire logic [COL_W-1:0]  arrayCol,
  input wire logic [DATA_W-1:0] dqOut,
  input wire logic              dqOe,
  input wire logic              inBufEn,
  input wire logic              clkSuspended,
  input wire logic              powerDown
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence ckeHeld; clkEn [*6]; endsequence
  sequence frozen; clkSuspended [*2]; endsequence
  a_pd_bufs: assert property (
    powerDown |-> !inBufEn) else $error("buffers on in power-down");
  a_pd_exit: assert property (
    $fell(powerDown) |-> inBufEn) else $error("buffers off after exit");
  a_wake_up: assert property (
    ckeHeld |-> !clkSuspended && !powerDown) else $error("no restart");
  a_hold_out: assert property (
    frozen |-> $stable(arrayCol) && $stable(dqOut)) else $error("moved");
  a_susp_wr: assert property (
    frozen |-> !arrayWrEn) else $error("write while suspended");
  a_susp_entry: assert property (
    $rose(clkSuspended) |-> !$past(clkEn, 3) || !$past(clkEn, 4))
    else $error("suspend without cause");
  a_mask_wr: assert property (
    arrayWrEn |-> !$past(dataMask, 3)) else $error("masked word stored");
  a_mask_rd: assert property (
    dqOe |-> !($past(dataMask, 3) && $past(dataMask, 4)))
    else $error("driving while masked");
endmodule
bind scg_clock_gate_mask scg_clock_gate_mask_monitor #(.DATA_W(DATA_W),
  .COL_W(COL_W)) u_mon (.clk, .rst_n, .clkEn, .dataMask, .arrayWrEn,
  .arrayCol, .dqOut, .dqOe, .inBufEn, .clkSuspended, .powerDown);

// ==== scg_clock_gate_mask_tb_top.sv ====
`timescale 1ns/1ns
module scg_clock_gate_mask_tb_top;
  logic              clk = 1'b0, rst_n = 1'b0, clkEn = 1'b1;
  logic              dataMask = 1'b0, arrayWrEn, dqOe;
  logic              inBufEn, clkSuspended, powerDown;
  scg_pkg::scg_cmd_t cmd = scg_pkg::SCG_CMD_NOP;
  logic [9:0]        colAddr = 10'h000, arrayCol;
  logic [10:0]       burstLen = 11'h001;
  logic [15:0]       dqIn = 16'h0000, arrayRdData, arrayWrData, dqOut;
  logic [31:0]       seed = 32'h6CB33BAB;
  logic [15:0]       shadow [1024];
  logic [25:0]       wrQ [$], rdQ [$];
  int                failures = 0, n_compared = 0;
  always #50 clk = ~clk;
  scg_clock_gate_mask DUT (.clk, .rst_n, .clkEn, .dataMask, .cmd, .colAddr,
    .burstLen, .dqIn, .arrayRdData, .arrayWrEn, .arrayCol, .arrayWrData,
    .dqOut, .dqOe, .inBufEn, .clkSuspended, .powerDown);
  scg_array_model u_array (.clk, .wrEn(arrayWrEn), .col(arrayCol),
    .wrData(arrayWrData), .rdData(arrayRdData));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // An empty queue yields z so that a spare output can never match.
  function automatic logic [25:0] pop(ref logic [25:0] q[$]);
    return q.size() ? q.pop_front() : 'z;
  endfunction
  task automatic tick(); @(posedge clk); #2; endtask
  task automatic check(logic [25:0] seen, logic [25:0] exp, string what);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // A word counts only if clock enable was high the cycle before.
  task automatic burst(bit wr, logic [9:0] col, int len, logic [31:0] msk,
                       logic [31:0] cke);
    bit prev = 1'b1;
    int k = 0;
    cmd = wr ? scg_pkg::SCG_CMD_WRITE : scg_pkg::SCG_CMD_READ;
    colAddr = col;
    burstLen = 11'(len);
    tick();
    cmd = scg_pkg::SCG_CMD_NOP;
    for (int c = 0; k < len && c < 32; c++) begin
      dataMask = msk[c];
      clkEn = cke[c];
      dqIn = 16'(rnd());
      if (prev && !dataMask && wr) shadow[col + 10'(k)] = dqIn;
      if (prev && !dataMask && wr) wrQ.push_back({col + 10'(k), dqIn});
      if (prev && !dataMask && !wr) rdQ.push_back({10'h0, shadow[col + 10'(k)]});
      k += int'(prev);
      prev = clkEn;
      tick();
      cmd = scg_pkg::SCG_CMD_NOP;
    end
    check(26'(k), 26'(len), "len");
    clkEn = 1'b1;
    dataMask = 1'b0;
    repeat (8) tick();
  endtask
  always @(negedge clk) begin
    if (rst_n && arrayWrEn)
      check({arrayCol, arrayWrData}, pop(wrQ), "wr");
    if (rst_n && dqOe)
      check({10'h0, dqOut}, pop(rdQ), "rd");
  end
  initial begin
    logic [9:0] col;
    repeat (4) @(posedge clk);
    #2 rst_n = 1'b1;
    tick();
    col = 10'(rnd());
    burst(1'b1, 10'h3FE, 4, 32'h2, '1);
    burst(1'b1, col, 6, 32'h0, 32'hFFFFFFC7);
    burst(1'b0, col, 6, 32'h0, '1);
    burst(1'b0, col, 3, '1, '1);
    clkEn = 1'b0;
    repeat (6) tick();
    check({24'h0, powerDown, inBufEn}, 26'h2, "pd");
    clkEn = 1'b1;
    for (int i = 0; i < 8 && powerDown !== 1'b0; i++) tick();
    check({24'h0, powerDown, inBufEn}, 26'h1, "wake");
    if (powerDown !== 1'b0) give_verdict();
    repeat (scg_pkg::PDE_CYC + 1) tick();
    burst(1'b1, col, 1, 32'h0, '1);
    check(26'(wrQ.size() + rdQ.size()), 26'h0, "left");
    give_verdict();
  end
endmodule
